// File: hw/bmss_sequencer.v
// Purpose: buck mode and start-up sequencer with apb registers
// Assumes: all pins synchronous to clock_i; analog comparisons arrive as flags
// Notes: soft-start ramp is a digital set-point counter
//
// Decided for this implementation: register access over APB and the placing of the registers.
`include "bmss_consts.vh"
module bmss_sequencer #(
    parameter START_DLY_CYC = `BMSS_START_DLY_CYC
) (
    input wire clock_i,
    input wire resetn_i,
    input wire supply_por_ok_i,
    input wire converter_enable_in_i,
    input wire [`BMSS_VID_W-1:0] voltage_id_code_i,
    input wire force_diode_emul_pin_i,
    input wire audio_filter_enable_pin_i,
    input wire pwm_pulse_i,
    input wire low_side_gate_rise_i,
    input wire phase_positive_i,
    input wire vout_in_window_i,
    input wire severe_overvoltage_level_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`BMSS_ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    output wire power_good_out_o,
    output wire power_good_out_oe_n_o,
    output wire converter_active_o,
    output wire low_side_sync_en_o,
    output wire diode_emulation_state_o,
    output wire window_boost_o,
    output wire audio_filter_on_o,
    output wire [`BMSS_VID_W-1:0] target_code_o,
    output wire [`BMSS_RAMP_W-1:0] ramp_level_o,
    output wire irq_o
);
    localparam S_OFF = 5'b00001;
    localparam S_DELAY = 5'b00010;
    localparam S_RAMP = 5'b00100;
    localparam S_RUN = 5'b01000;
    localparam S_FAULT = 5'b10000;

    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [23:0] dly_ff;
    reg [`BMSS_RAMP_W-1:0] ramp_ff;
    reg [`BMSS_VID_W-1:0] code_ff;
    reg [`BMSS_CTRL_W-1:0] ctrl_ff;
    reg [`BMSS_IRQ_W-1:0] irq_stat_ff;
    reg [`BMSS_IRQ_W-1:0] irq_mask_ff;
    reg [31:0] prdata_ff;
    reg pg_ff;
    reg dem_ff;
    reg [`BMSS_VID_W-1:0] nxt_code;
    wire pg_done;
    wire dem_raw;
    wire dem_allow;
    wire apb_acc;
    wire apb_wr;
    wire apb_rd;
    wire hit;
    wire [`BMSS_IRQ_W-1:0] events;

    // suspend range is the top code bit
    function is_suspend;
        input [`BMSS_VID_W-1:0] code;
        begin
            is_suspend = code[`BMSS_VID_SUSP_BIT];
        end
    endfunction

    function addr_hit;
        input [`BMSS_ADDR_W-1:0] a;
        begin
            addr_hit = (a == `BMSS_OFS_CTRL) || (a == `BMSS_OFS_STATUS) ||
                (a == `BMSS_OFS_IRQ_STAT) || (a == `BMSS_OFS_IRQ_MASK) ||
                (a == `BMSS_OFS_SET_PT);
        end
    endfunction

    wire enabled = supply_por_ok_i && converter_enable_in_i;

    // sequencing state machine
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_OFF: begin
                if (enabled && !ctrl_ff[`BMSS_CTRL_SHUTDOWN]) begin
                    nxt_state = S_DELAY;
                end
            end
            S_DELAY: begin
                if (dly_ff == START_DLY_CYC - 1) begin
                    nxt_state = S_RAMP;
                end
            end
            S_RAMP: begin
                if (pg_done) begin
                    nxt_state = S_RUN;
                end
            end
            S_RUN: begin
                nxt_state = S_RUN;
            end
            S_FAULT: begin
                // only a supply cycle clears a severe overvoltage latch
                nxt_state = S_FAULT;
            end
            default: begin
                nxt_state = S_OFF;
            end
        endcase
        if (!supply_por_ok_i) begin
            nxt_state = S_OFF;
        end else if (severe_overvoltage_level_i || state_ff == S_FAULT) begin
            nxt_state = S_FAULT;
        end else if (!converter_enable_in_i || ctrl_ff[`BMSS_CTRL_SHUTDOWN]) begin
            nxt_state = S_OFF;
        end
    end

    // target code follows pins one cycle later; a new code does not restart the ramp
    always @* begin
        nxt_code = voltage_id_code_i;
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            state_ff <= S_OFF;
            dly_ff <= 24'h0;
            ramp_ff <= {`BMSS_RAMP_W{1'b0}};
            code_ff <= {`BMSS_VID_W{1'b0}};
            pg_ff <= 1'b0;
            dem_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            code_ff <= nxt_code;
            dly_ff <= (state_ff == S_DELAY) ? dly_ff + 24'h1 : 24'h0;
            if (state_ff == S_RAMP || state_ff == S_RUN) begin
                if (ramp_ff != {`BMSS_RAMP_W{1'b1}}) begin
                    ramp_ff <= ramp_ff + `BMSS_RAMP_STEP;
                end
            end else begin
                ramp_ff <= {`BMSS_RAMP_W{1'b0}};
            end
            pg_ff <= (nxt_state == S_RUN);
            dem_ff <= dem_raw;
        end
    end

    // dem permission only outside soft-start
    assign dem_allow = (state_ff == S_RUN) && !ctrl_ff[`BMSS_CTRL_FORCE_CCM] &&
        (force_diode_emul_pin_i || is_suspend(code_ff));

    bmss_pg_cnt #(
        .PG_CYCLES(`BMSS_PG_CYCLES)
    ) u_pg (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .arm_i((state_ff == S_RAMP || state_ff == S_RUN) && vout_in_window_i),
        .cyc_i(pwm_pulse_i),
        .done_o(pg_done)
    );

    bmss_dem_ctl #(
        .ENTRY_CNT(`BMSS_DEM_ENTRY)
    ) u_dem (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .allow_i(dem_allow),
        .lg_rise_i(low_side_gate_rise_i),
        .phase_pos_i(phase_positive_i),
        .dem_o(dem_raw)
    );

    // open drain: enable low pulls the pin low; released once good
    assign power_good_out_o = 1'b0;
    assign power_good_out_oe_n_o = pg_ff;
    assign converter_active_o = (state_ff == S_RAMP) || (state_ff == S_RUN);
    assign diode_emulation_state_o = dem_raw;
    assign low_side_sync_en_o = converter_active_o && !dem_raw;
    assign audio_filter_on_o = audio_filter_enable_pin_i;
    assign window_boost_o = dem_raw && !audio_filter_enable_pin_i;
    assign target_code_o = code_ff;
    assign ramp_level_o = ramp_ff;

    // apb slave, zero wait states
    assign apb_acc = psel_i && penable_i;
    assign apb_wr = apb_acc && pwrite_i;
    assign apb_rd = apb_acc && !pwrite_i;
    assign hit = addr_hit(paddr_i);
    assign pready_o = 1'b1;
    assign pslverr_o = apb_acc && !hit;
    assign events = {state_ff != S_FAULT && nxt_state == S_FAULT,
        dem_ff && !dem_raw, !dem_ff && dem_raw, !pg_ff && nxt_state == S_RUN};

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            ctrl_ff <= `BMSS_CTRL_RST;
            irq_mask_ff <= {`BMSS_IRQ_W{1'b0}};
            irq_stat_ff <= {`BMSS_IRQ_W{1'b0}};
        end else begin
            if (apb_wr && paddr_i == `BMSS_OFS_CTRL) begin
                ctrl_ff <= pwdata_i[`BMSS_CTRL_W-1:0];
            end
            if (apb_wr && paddr_i == `BMSS_OFS_IRQ_MASK) begin
                irq_mask_ff <= pwdata_i[`BMSS_IRQ_W-1:0];
            end
            // a new event in the clearing read cycle still sets its bit
            if (apb_rd && paddr_i == `BMSS_OFS_IRQ_STAT) begin
                irq_stat_ff <= events;
            end else begin
                irq_stat_ff <= irq_stat_ff | events;
            end
        end
    end

    always @* begin
        prdata_ff = `BMSS_ZERO32;
        case (paddr_i)
            `BMSS_OFS_CTRL: prdata_ff[`BMSS_CTRL_W-1:0] = ctrl_ff;
            `BMSS_OFS_STATUS: prdata_ff[9:0] = {pg_ff, dem_raw, state_ff, 3'h0};
            `BMSS_OFS_IRQ_STAT: prdata_ff[`BMSS_IRQ_W-1:0] = irq_stat_ff;
            `BMSS_OFS_IRQ_MASK: prdata_ff[`BMSS_IRQ_W-1:0] = irq_mask_ff;
            `BMSS_OFS_SET_PT: prdata_ff[`BMSS_VID_W-1:0] = code_ff;
            default: prdata_ff = `BMSS_ZERO32;
        endcase
    end

    assign prdata_o = prdata_ff;
    assign irq_o = |(irq_stat_ff & irq_mask_ff);
endmodule

// File: hw/bmss_consts.vh
// Purpose: shared constants of the buck mode and start-up sequencer
// Assumes: 20 MHz system clock, 50 ns period
// Notes: apb byte offsets, field positions and timing figures
`ifndef BMSS_CONSTS_VH
`define BMSS_CONSTS_VH

`define BMSS_CLK_HZ 20000000
`define BMSS_START_DLY_US 100
`define BMSS_START_DLY_CYC ((`BMSS_START_DLY_US * `BMSS_CLK_HZ) / 1000000)
`define BMSS_PG_CYCLES 6
`define BMSS_DEM_ENTRY 8
`define BMSS_VID_W 5
`define BMSS_VID_SUSP_BIT 4

`define BMSS_ADDR_W 12
`define BMSS_OFS_CTRL 12'h000
`define BMSS_OFS_STATUS 12'h004
`define BMSS_OFS_IRQ_STAT 12'h008
`define BMSS_OFS_IRQ_MASK 12'h00c
`define BMSS_OFS_SET_PT 12'h010

`define BMSS_CTRL_W 2
`define BMSS_CTRL_RST 2'h0
`define BMSS_CTRL_FORCE_CCM 0
`define BMSS_CTRL_SHUTDOWN 1

`define BMSS_IRQ_W 4
`define BMSS_IRQ_POWER_GOOD_OUT 0
`define BMSS_IRQ_DEM_IN 1
`define BMSS_IRQ_DEM_OUT 2
`define BMSS_IRQ_FAULT 3

`define BMSS_RAMP_W 16
`define BMSS_RAMP_STEP 16'h0001
`define BMSS_ZERO32 32'h00000000

`endif

// File: hw/bmss_dem_ctl.v
// Purpose: conduction mode selection from phase-node polarity per low-side gate rise
// Assumes: pulse and polarity sampled synchronous to clock_i
// Notes: ccm in reset, during soft-start and while not allowed
`include "bmss_consts.vh"
module bmss_dem_ctl #(
    parameter ENTRY_CNT = `BMSS_DEM_ENTRY
) (
    input wire clock_i,
    input wire resetn_i,
    input wire allow_i,
    input wire lg_rise_i,
    input wire phase_pos_i,
    output wire dem_o
);
    localparam S_CCM = 2'b01;
    localparam S_DEM = 2'b10;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [3:0] cnt_ff;
    reg [3:0] nxt_cnt;

    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            S_CCM: begin
                if (!allow_i) begin
                    nxt_cnt = 4'h0;
                end else if (lg_rise_i) begin
                    if (!phase_pos_i) begin
                        nxt_cnt = 4'h0;
                    end else if (cnt_ff == ENTRY_CNT - 1) begin
                        nxt_cnt = 4'h0;
                        nxt_state = S_DEM;
                    end else begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
            end
            S_DEM: begin
                // leave at once on negative phase, so next cycle is ccm
                if (!allow_i || (lg_rise_i && !phase_pos_i)) begin
                    nxt_state = S_CCM;
                    nxt_cnt = 4'h0;
                end
            end
            default: begin
                nxt_state = S_CCM;
                nxt_cnt = 4'h0;
            end
        endcase
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            state_ff <= S_CCM;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign dem_o = (state_ff == S_DEM);
endmodule

// File: hw/bmss_pg_cnt.v
// Purpose: power-good qualification counter
// Assumes: one pulse per switching cycle on cyc_i
// Notes: any loss of arm clears the count
`include "bmss_consts.vh"
module bmss_pg_cnt #(
    parameter PG_CYCLES = `BMSS_PG_CYCLES
) (
    input wire clock_i,
    input wire resetn_i,
    input wire arm_i,
    input wire cyc_i,
    output wire done_o
);
    reg [3:0] cnt_ff;
    reg done_ff;

    always @(posedge clock_i) begin
        if (!resetn_i || !arm_i) begin
            cnt_ff <= 4'h0;
            done_ff <= 1'b0;
        end else if (cyc_i && !done_ff) begin
            if (cnt_ff == PG_CYCLES - 1) begin
                done_ff <= 1'b1;
            end
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    assign done_o = done_ff;
endmodule

// File: sim/bmss_stage_model.sv
// Purpose: power stage stand-in driving pwm pulses and phase polarity
// Assumes: one switching cycle every four clocks
// Notes: polarity is only defined at the low-side gate edge
module bmss_stage_model (
    input wire logic clock_i,
    input wire logic run_i,
    input wire logic neg_i,
    output logic pwm_pulse_o,
    output logic lg_rise_o,
    output logic phase_pos_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_ff = 2'h0;
    always @(posedge clock_i) begin
        ph_ff <= ph_ff + 2'h1;
        pwm_pulse_o <= run_i && ph_ff == 2'h0;
        lg_rise_o <= run_i && ph_ff == 2'h1;
        // off the gate edge the node wanders, so a stale value never reads as valid
        phase_pos_o <= (run_i && ph_ff == 2'h1) ? !neg_i : !phase_pos_o;
    end
endmodule

// File: sim/bmss_seq_chk.sv
// Purpose: port-level checks of the buck mode and start-up sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: small counters stand in for long waits
`include "bmss_consts.vh"
module bmss_seq_chk #(
    parameter START_DLY_CYC = 20
) (
    input wire clock_i,
    input wire resetn_i,
    input wire supply_por_ok_i,
    input wire converter_enable_in_i,
    input wire [`BMSS_VID_W-1:0] voltage_id_code_i,
    input wire force_diode_emul_pin_i,
    input wire audio_filter_enable_pin_i,
    input wire pwm_pulse_i,
    input wire low_side_gate_rise_i,
    input wire phase_positive_i,
    input wire vout_in_window_i,
    input wire severe_overvoltage_level_i,
    input wire power_good_out_o,
    input wire power_good_out_oe_n_o,
    input wire converter_active_o,
    input wire low_side_sync_en_o,
    input wire diode_emulation_state_o,
    input wire window_boost_o,
    input wire audio_filter_on_o,
    input wire [`BMSS_VID_W-1:0] target_code_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic [9:0] dly_ff;
    logic [3:0] pg_ff;
    logic [3:0] pos_ff;
    // counters saturate so a long run never wraps into a false match
    always @(posedge clock_i) begin
        if (!resetn_i || !supply_por_ok_i || !converter_enable_in_i || converter_active_o)
            dly_ff <= 10'h000;
        else if (dly_ff != 10'h3ff)
            dly_ff <= dly_ff + 10'h001;
        if (!resetn_i || !converter_active_o || !vout_in_window_i)
            pg_ff <= 4'h0;
        else if (pwm_pulse_i && pg_ff != 4'hf)
            pg_ff <= pg_ff + 4'h1;
        if (!resetn_i || (low_side_gate_rise_i && !phase_positive_i))
            pos_ff <= 4'h0;
        else if (low_side_gate_rise_i && pos_ff != 4'hf)
            pos_ff <= pos_ff + 4'h1;
    end
    sequence neg_seen;
        low_side_gate_rise_i && !phase_positive_i;
    endsequence
    sequence idle_two;
        !converter_active_o [*2];
    endsequence
    por_off_a: assert property (!supply_por_ok_i |=> !converter_active_o)
        else $error("active without supply");
    en_off_a: assert property (!converter_enable_in_i |=> !converter_active_o)
        else $error("active without enable");
    start_dly_a: assert property ($rose(converter_active_o) |->
        dly_ff >= START_DLY_CYC - 1 && dly_ff <= START_DLY_CYC + 3) else $error("start delay");
    pg_count_a: assert property ($rose(power_good_out_oe_n_o) |->
        pg_ff == `BMSS_PG_CYCLES && vout_in_window_i) else $error("power good early");
    pg_low_a: assert property (idle_two |-> !power_good_out_oe_n_o && !power_good_out_o)
        else $error("power good while idle");
    ramp_ccm_a: assert property (converter_active_o && !power_good_out_oe_n_o |->
        !diode_emulation_state_o) else $error("dem in soft-start");
    sync_rect_a: assert property (low_side_sync_en_o ==
        (converter_active_o && !diode_emulation_state_o)) else $error("low side mode");
    dem_allow_a: assert property ($rose(diode_emulation_state_o) |->
        force_diode_emul_pin_i || target_code_o[`BMSS_VID_SUSP_BIT]) else $error("dem barred");
    dem_entry_a: assert property ($rose(diode_emulation_state_o) |-> pos_ff >= 4'h8)
        else $error("dem entry count");
    dem_exit_a: assert property (diode_emulation_state_o ##0 neg_seen |=>
        !diode_emulation_state_o) else $error("dem exit");
    boost_a: assert property (window_boost_o ==
        (diode_emulation_state_o && !audio_filter_enable_pin_i)) else $error("window boost");
    audio_pin_a: assert property (audio_filter_on_o == audio_filter_enable_pin_i)
        else $error("audio filter");
    ov_off_a: assert property (severe_overvoltage_level_i |=> !converter_active_o)
        else $error("overvoltage");
    code_track_a: assert property (1'b1 |=> target_code_o == $past(voltage_id_code_i))
        else $error("set-point code");
endmodule
bind bmss_sequencer bmss_seq_chk #(.START_DLY_CYC(START_DLY_CYC)) chk_u (.*);

// File: sim/bmss_tb.sv
// Purpose: self-checking bench of the buck mode and start-up sequencer
// Assumes: 20 MHz clock, start delay shortened to 20 cycles
// Notes: outputs are looked at on the falling edge, after updates land
`include "bmss_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic f; logic [4:0] c; logic a; logic d; logic b;} bmss_row_t;
    bmss_row_t rows [8] = '{9'h018, 9'h11b, 9'h01c, 9'h11e, 9'h09b, 9'h19b, 9'h09e, 9'h1fe};
    logic clock_i = 1'b0, resetn_i = 1'b0, supply_por_ok_i = 1'b0, converter_enable_in_i = 1'b0;
    logic force_diode_emul_pin_i = 1'b0, audio_filter_enable_pin_i = 1'b0, vout_in_window_i = 1'b0;
    logic severe_overvoltage_level_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [4:0] voltage_id_code_i = 5'h03;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000, rd;
    logic run = 1'b0, neg = 1'b0, se;
    wire pwm_pulse_i, low_side_gate_rise_i, phase_positive_i, pready_o, pslverr_o, irq_o;
    wire power_good_out_o, power_good_out_oe_n_o, converter_active_o, low_side_sync_en_o;
    wire diode_emulation_state_o, window_boost_o, audio_filter_on_o;
    wire [31:0] prdata_o;
    wire [4:0] target_code_o;
    wire [15:0] ramp_level_o;
    int fails = 0, checks = 0;
    always #25 clock_i = ~clock_i;
    bmss_sequencer #(.START_DLY_CYC(20)) dut_u (.*);
    bmss_stage_model stage_u (.clock_i, .run_i(run), .neg_i(neg), .pwm_pulse_o(pwm_pulse_i),
        .lg_rise_o(low_side_gate_rise_i), .phase_pos_o(phase_positive_i));
    task automatic give_verdict;
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        logic ok;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        // answer is read settled, just before the edge that takes it
        do begin
            @(negedge clock_i);
            n++;
            ok = pready_o;
            rd = prdata_o;
            se = pslverr_o;
            @(posedge clock_i);
        end while (ok !== 1'b1 && n < 50);
        if (ok !== 1'b1)
            fails++;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wait_pg;
        int n = 0;
        while (power_good_out_oe_n_o !== 1'b1 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
        `CHK(power_good_out_oe_n_o, 1'b1)
    endtask
    initial begin
        cyc(10);
        resetn_i <= 1'b1;
        look(2);
        `CHK(power_good_out_oe_n_o, 1'b0)
        `CHK({converter_active_o, irq_o, power_good_out_o, ramp_level_o}, 19'h0)
        cyc(1);
        vout_in_window_i <= 1'b1;
        run <= 1'b1;
        supply_por_ok_i <= 1'b1;
        look(10);
        `CHK(converter_active_o, 1'b0)
        cyc(1);
        converter_enable_in_i <= 1'b1;
        look(12);
        `CHK(converter_active_o, 1'b0)
        wait_pg;
        `CHK(converter_active_o, 1'b1)
        apb(1'b1, `BMSS_OFS_IRQ_MASK, 32'h0000000f);
        apb(1'b0, `BMSS_OFS_IRQ_MASK, 32'h00000000);
        `CHK(rd, 32'h0000000f)
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            force_diode_emul_pin_i <= rows[i].f;
            voltage_id_code_i <= rows[i].c;
            audio_filter_enable_pin_i <= rows[i].a;
            look(48);
            `CHK(diode_emulation_state_o, rows[i].d)
            `CHK(window_boost_o, rows[i].b)
            `CHK(audio_filter_on_o, rows[i].a)
            `CHK(low_side_sync_en_o, !rows[i].d)
            `CHK(target_code_o, rows[i].c)
            cyc(1);
            neg <= 1'b1;
            cyc(5);
            neg <= 1'b0;
            look(3);
            `CHK(diode_emulation_state_o, 1'b0)
        end
        apb(1'b1, `BMSS_OFS_CTRL, 32'h00000001);
        look(48);
        `CHK(diode_emulation_state_o, 1'b0)
        apb(1'b1, `BMSS_OFS_CTRL, 32'h00000000);
        cyc(1);
        run <= 1'b0;
        look(2);
        `CHK(irq_o, 1'b1)
        apb(1'b1, `BMSS_OFS_IRQ_MASK, 32'h00000000);
        look(0);
        `CHK(irq_o, 1'b0)
        apb(1'b0, `BMSS_OFS_IRQ_STAT, 32'h00000000);
        `CHK(rd, 32'h00000007)
        apb(1'b0, `BMSS_OFS_IRQ_STAT, 32'h00000000);
        `CHK(rd, 32'h00000000)
        apb(1'b0, 12'h100, 32'h00000000);
        `CHK({se, rd}, 33'h100000000) // unmapped place answers with an error
        cyc(1);
        run <= 1'b1;
        severe_overvoltage_level_i <= 1'b1;
        cyc(2);
        severe_overvoltage_level_i <= 1'b0;
        look(4);
        `CHK({converter_active_o, power_good_out_oe_n_o}, 2'h0)
        cyc(1);
        converter_enable_in_i <= 1'b0;
        supply_por_ok_i <= 1'b0;
        look(3);
        `CHK(converter_active_o, 1'b0)
        cyc(1);
        supply_por_ok_i <= 1'b1;
        cyc(2);
        converter_enable_in_i <= 1'b1;
        wait_pg;
        cyc(1);
        resetn_i <= 1'b0;
        cyc(2);
        resetn_i <= 1'b1;
        look(1);
        `CHK({power_good_out_oe_n_o, converter_active_o}, 2'h0)
        give_verdict;
    end
    initial begin
        #1000000;
        fails++;
        give_verdict;
    end
endmodule
